// ### design/logic_cell_gate_select.sv
`timescale 1ns/1ps
`default_nettype none
module logic_cell_gate_select
	import gate_sel_pkg::*;
(
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [DATA_W-1:0]    reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [DATA_W-1:0]    reg_rdata,
	// Cell sources and outputs
	input  wire logic [NUM_SRC-1:0]   cell_sources,
	input  wire logic                 first_cell_output,
	input  wire logic                 second_cell_output,
	// Gate results and selected data toward the logic function
	output logic      [NUM_GATES-1:0] gate_out,
	output logic      [NUM_DATA-1:0]  data_out
);
	////////////////////////////////////////////////////////////////////////
	logic [DATA_W-1:0]       sel_reg   [NUM_GATES];
	logic [DATA_W-1:0]       src_lo_reg;
	logic [DATA_W-1:0]       src_hi_reg;
	logic [1:0]              cell_meta_reg;
	logic [1:0]              cell_sync_reg;
	logic [DATA_W-1:0]       mirror_reg;
	logic [NUM_DATA-1:0]     data_reg;
	logic [NUM_GATES-1:0]    gate_reg;
	logic [DATA_W-1:0]       rdata_next;
	logic [NUM_GATES-1:0]    sel_seen_reg;
	gate_sel_if              gif ();

	function automatic logic [SRC_SEL_W-1:0] field(input logic [DATA_W-1:0] r,
		input int pos);
		field = r[pos +: SRC_SEL_W];
	endfunction : field

	function automatic logic gate_wr_hit(input logic wr, input logic [ADDR_W-1:0] addr,
		input int idx);
		gate_wr_hit = wr && addr == ADDR_GATE1 + ADDR_W'(idx);
	endfunction : gate_wr_hit

	// Each data signal as the true/inverted pair that a select byte masks
	function automatic logic [DATA_W-1:0] term_vec(input logic [NUM_DATA-1:0] d);
		for (int k = 0; k < NUM_DATA; k++) begin
			term_vec[2*k+1] = d[k];
			term_vec[2*k]   = ~d[k];
		end
	endfunction : term_vec

	////////////////////////////////////////////////////////////////////////
	// Select registers: no reset, so power-on value is unknown and other
	// resets leave them alone
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NUM_GATES; i++) begin
			if (gate_wr_hit(reg_wr, reg_addr, i)) begin
				sel_reg[i] <= reg_wdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			src_lo_reg <= SRC_RST;
			src_hi_reg <= SRC_RST;
		end else begin
			if (reg_wr && reg_addr == ADDR_SRC_LO) begin
				src_lo_reg <= reg_wdata;
			end
			if (reg_wr && reg_addr == ADDR_SRC_HI) begin
				src_hi_reg <= reg_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data input selection: 3-bit field chooses within a window that wraps at
	// sixteen. Sources arrive from other logic on other clocks: synchronise first
	logic [NUM_SRC-1:0] src_meta_reg;
	logic [NUM_SRC-1:0] src_sync_reg;
	logic [NUM_DATA-1:0] data_sel_comb;
	always_comb begin
		logic [SRC_SEL_W-1:0] f2;
		f2 = '0;
		for (int d = 0; d < NUM_DATA; d++) begin
			f2 = (d < 2) ? field(src_lo_reg, (d == 0) ? SRC_LO_POS : SRC_HI_POS)
				: field(src_hi_reg, (d == 2) ? SRC_LO_POS : SRC_HI_POS);
			data_sel_comb[d] = src_sync_reg[SRC_BASE[d] + {1'b0, f2}];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			src_meta_reg <= '0;
			src_sync_reg <= '0;
			data_reg     <= '0;
		end else begin
			src_meta_reg <= cell_sources;
			src_sync_reg <= src_meta_reg;
			data_reg     <= data_sel_comb;
		end
	end

	assign gif.data = data_reg;
	for (genvar gi = 0; gi < NUM_GATES; gi++) begin : gen_sel
		assign gif.sel[gi] = sel_reg[gi];
	end

	gate_or_core u_core (
		.g (gif)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gate_reg <= '0;
		end else begin
			gate_reg <= gif.gate;
		end
	end
	assign gate_out = gate_reg;
	assign data_out = data_reg;

	////////////////////////////////////////////////////////////////////////
	// Cell output mirror, synchronised
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cell_meta_reg <= '0;
			cell_sync_reg <= '0;
			mirror_reg    <= MIRROR_RST;
		end else begin
			cell_meta_reg <= {second_cell_output, first_cell_output};
			cell_sync_reg <= cell_meta_reg;
			mirror_reg    <= {{(DATA_W-2){1'b0}}, cell_sync_reg};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port
	always_comb begin
		rdata_next = UNMAPPED_VAL;
		unique case (reg_addr)
			ADDR_GATE1:  rdata_next = sel_reg[0];
			ADDR_GATE2:  rdata_next = sel_reg[1];
			ADDR_GATE3:  rdata_next = sel_reg[2];
			ADDR_GATE4:  rdata_next = sel_reg[3];
			ADDR_MIRROR: rdata_next = mirror_reg;
			ADDR_SRC_LO: rdata_next = src_lo_reg;
			ADDR_SRC_HI: rdata_next = src_hi_reg;
			default:     rdata_next = UNMAPPED_VAL;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Check helper: a select byte is unknown until written, so the hold checks
	// wait for a first write; rst_n clears it, so the over-reset hold checks cover only the first cycle of each reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sel_seen_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_GATES; i++) begin
				if (gate_wr_hit(reg_wr, reg_addr, i)) begin
					sel_seen_reg[i] <= 1'b1;
				end
			end
		end
	end

	sequence s_wr_gate2;
		reg_wr && reg_addr == ADDR_GATE2;
	endsequence
	sequence s_rd_mirror;
		reg_rd && reg_addr == ADDR_MIRROR;
	endsequence
	sequence s_wr_gate3;
		reg_wr && reg_addr == ADDR_GATE3;
	endsequence
	sequence s_rd_gate3;
		reg_rd && reg_addr == ADDR_GATE3;
	endsequence

	chk_gate2_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_wr_gate2 |=> sel_reg[1] == $past(reg_wdata))
		else $error("gate two select not written");
	chk_gate3_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_wr_gate3 ##1 s_rd_gate3 |=> reg_rdata == $past(reg_wdata, 2))
		else $error("gate three readback wrong");
	chk_gate4_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_seen_reg[3] && !(reg_wr && reg_addr == ADDR_GATE4) |=> $stable(sel_reg[3]))
		else $error("gate four select changed without write");
	chk_gate1_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_seen_reg[0] && !(reg_wr && reg_addr == ADDR_GATE1) |=> $stable(sel_reg[0]))
		else $error("gate one select changed without write");
	chk_none_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_reg[0] == '0 |=> !gate_reg[0])
		else $error("gate one high with nothing selected");
	chk_gate_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
		|(sel_reg[1] & {data_reg[3], ~data_reg[3], data_reg[2], ~data_reg[2],
			data_reg[1], ~data_reg[1], data_reg[0], ~data_reg[0]})
		|=> gate_reg[1])
		else $error("gate two missed a selected term");
	chk_src_pick: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$stable(src_lo_reg) |=> data_reg[0]
			== $past(src_sync_reg[SRC_BASE[0] + {1'b0, src_lo_reg[2:0]}]))
		else $error("data one source wrong");
	chk_mirror_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##3 mirror_reg[1:0] == $past({second_cell_output, first_cell_output}, 3))
		else $error("mirror lags cell outputs");
	chk_mirror_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_rd_mirror |=> reg_rdata[DATA_W-1:2] == '0)
		else $error("mirror upper bits nonzero");
	chk_sel_readable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == ADDR_GATE1 |=> reg_rdata == $past(sel_reg[0]))
		else $error("gate one select read wrong");

	// Select registers take writes, hold between them and over rst_n
	chk_gate1_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == ADDR_GATE1 |=> sel_reg[0] == $past(reg_wdata))
		else $error("gate one select not written");
	chk_gate3_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == ADDR_GATE3 |=> sel_reg[2] == $past(reg_wdata))
		else $error("gate three select not written");
	chk_gate4_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr && reg_addr == ADDR_GATE4 |=> sel_reg[3] == $past(reg_wdata))
		else $error("gate four select not written");
	chk_gate2_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_seen_reg[1] && !(reg_wr && reg_addr == ADDR_GATE2) |=> $stable(sel_reg[1]))
		else $error("gate two select changed without write");
	chk_gate3_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_seen_reg[2] && !(reg_wr && reg_addr == ADDR_GATE3) |=> $stable(sel_reg[2]))
		else $error("gate three select changed without write");
	chk_gate2_hold_rst: assert property (@(posedge sys_clk)
		!rst_n && sel_seen_reg[1] |=> $stable(sel_reg[1]))
		else $error("gate two select lost over reset");
	chk_gate3_hold_rst: assert property (@(posedge sys_clk)
		!rst_n && sel_seen_reg[2] |=> $stable(sel_reg[2]))
		else $error("gate three select lost over reset");
	chk_rd_gate2: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == ADDR_GATE2 |=> reg_rdata == $past(sel_reg[1]))
		else $error("gate two select read wrong");
	chk_rd_gate4: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd && reg_addr == ADDR_GATE4 |=> reg_rdata == $past(sel_reg[3]))
		else $error("gate four select read wrong");

	// Gate results follow the selected terms one cycle later
	chk_gate2_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_reg[1] == '0 |=> !gate_reg[1])
		else $error("gate two high with nothing selected");
	chk_gate3_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_reg[2] == '0 |=> !gate_reg[2])
		else $error("gate three high with nothing selected");
	chk_gate4_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sel_reg[3] == '0 |=> !gate_reg[3])
		else $error("gate four high with nothing selected");
	chk_gate1_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
		|(sel_reg[0] & term_vec(data_reg)) |=> gate_reg[0])
		else $error("gate one missed a selected term");
	chk_gate3_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
		|(sel_reg[2] & term_vec(data_reg)) |=> gate_reg[2])
		else $error("gate three missed a selected term");
	chk_gate4_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
		|(sel_reg[3] & term_vec(data_reg)) |=> gate_reg[3])
		else $error("gate four missed a selected term");
	chk_gate1_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(|(sel_reg[0] & term_vec(data_reg))) |=> !gate_reg[0])
		else $error("gate one high with no selected term true");
	chk_gate2_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(|(sel_reg[1] & term_vec(data_reg))) |=> !gate_reg[1])
		else $error("gate two high with no selected term true");
	chk_gate3_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(|(sel_reg[2] & term_vec(data_reg))) |=> !gate_reg[2])
		else $error("gate three high with no selected term true");
	chk_gate4_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(|(sel_reg[3] & term_vec(data_reg))) |=> !gate_reg[3])
		else $error("gate four high with no selected term true");

	// Source picks for the other three data signals
	chk_src_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> data_reg[1]
			== $past(src_sync_reg[SRC_BASE[1] + {1'b0, field(src_lo_reg, SRC_HI_POS)}]))
		else $error("data two source wrong");
	chk_src_three: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> data_reg[2]
			== $past(src_sync_reg[SRC_BASE[2] + {1'b0, field(src_hi_reg, SRC_LO_POS)}]))
		else $error("data three source wrong");
	chk_src_four: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> data_reg[3]
			== $past(src_sync_reg[SRC_BASE[3] + {1'b0, field(src_hi_reg, SRC_HI_POS)}]))
		else $error("data four source wrong");

	// Mirror clears on reset and reads back as held
	chk_mirror_reset: assert property (@(posedge sys_clk)
		!rst_n |=> mirror_reg == MIRROR_RST)
		else $error("mirror not cleared by reset");
	chk_mirror_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_rd_mirror |=> reg_rdata == $past(mirror_reg))
		else $error("mirror read wrong");
endmodule : logic_cell_gate_select
`default_nettype wire

// ### design/gate_sel_pkg.sv
package gate_sel_pkg;
	localparam int          DATA_W       = 8;
	localparam int          ADDR_W       = 4;
	localparam int          NUM_GATES    = 4;
	localparam int          NUM_DATA     = 4;
	localparam int          NUM_SRC      = 16;
	localparam int          SRC_SEL_W    = 3;
	localparam int          SRC_IDX_W    = 4;
	localparam logic [3:0]  ADDR_GATE1   = 4'h0;
	localparam logic [3:0]  ADDR_GATE2   = 4'h1;
	localparam logic [3:0]  ADDR_GATE3   = 4'h2;
	localparam logic [3:0]  ADDR_GATE4   = 4'h3;
	localparam logic [3:0]  ADDR_MIRROR  = 4'h4;
	localparam logic [3:0]  ADDR_SRC_LO  = 4'h5;
	localparam logic [3:0]  ADDR_SRC_HI  = 4'h6;
	localparam logic [7:0]  MIRROR_RST   = 8'h00;
	localparam logic [7:0]  SRC_RST      = 8'h00;
	localparam logic [7:0]  UNMAPPED_VAL = 8'h00;
	localparam int          SRC_LO_POS   = 0;
	localparam int          SRC_HI_POS   = 4;
	// Base offset of each data input's eight-source window, wrapping at sixteen
	localparam logic [3:0]  SRC_BASE [NUM_DATA] = '{4'h0, 4'h4, 4'h8, 4'hC};
endpackage : gate_sel_pkg

// ### design/gate_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface gate_sel_if;
	import gate_sel_pkg::*;
	logic [DATA_W-1:0]    sel   [NUM_GATES];
	logic [NUM_DATA-1:0]  data;
	logic [NUM_GATES-1:0] gate;
	modport ctrl (output sel, output data, input gate);
	modport core (input sel, input data, output gate);
endinterface : gate_sel_if
`default_nettype wire

// ### design/gate_or_core.sv
`timescale 1ns/1ps
`default_nettype none
module gate_or_core
	import gate_sel_pkg::*;
(
	gate_sel_if.core g
);
	// Bit 2k+1 is data k+1 true, bit 2k is data k+1 inverted
	for (genvar gi = 0; gi < NUM_GATES; gi++) begin : gen_gate
		logic [DATA_W-1:0] terms;
		for (genvar di = 0; di < NUM_DATA; di++) begin : gen_term
			assign terms[2*di+1] = g.sel[gi][2*di+1] & g.data[di];
			assign terms[2*di]   = g.sel[gi][2*di] & ~g.data[di];
		end
		assign g.gate[gi] = |terms;
	end
endmodule : gate_or_core
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import gate_sel_pkg::*;
;
	logic                 sys_clk            = 1'b0;
	logic                 rst_n              = 1'b0;
	logic [ADDR_W-1:0]    reg_addr           = '0;
	logic [DATA_W-1:0]    reg_wdata          = '0;
	logic                 reg_wr             = 1'b0;
	logic                 reg_rd             = 1'b0;
	logic [DATA_W-1:0]    reg_rdata;
	logic [NUM_SRC-1:0]   cell_sources       = '0;
	logic                 first_cell_output  = 1'b0;
	logic                 second_cell_output = 1'b0;
	logic [NUM_GATES-1:0] gate_out;
	logic [NUM_DATA-1:0]  data_out;
	int                   n_mismatch         = 0;
	int                   num_checks         = 0;
	integer               seed               = 19;
	logic [7:0]           exp_q [$];
	logic [7:0]           sel_m [4];
	logic                 rd_q1              = 1'b0;
	logic [7:0]           path_q [$];
	logic [7:0]           path_e;

	logic_cell_gate_select logic_cell_gate_select_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cell_sources(cell_sources),
		.first_cell_output(first_cell_output), .second_cell_output(second_cell_output),
		.gate_out(gate_out), .data_out(data_out));

	always #12.5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic compare(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : compare

	task automatic check_rdata(input logic [7:0] got, input logic [7:0] exp);
		compare(got, exp);
	endtask : check_rdata

	task automatic check_data(input logic [NUM_DATA-1:0] got, input logic [NUM_DATA-1:0] exp);
		compare(8'(got), 8'(exp));
	endtask : check_data

	task automatic check_gate(input logic [NUM_GATES-1:0] got, input logic [NUM_GATES-1:0] exp);
		compare(8'(got), 8'(exp));
	endtask : check_gate

	// Each signal is assigned once per edge, so strobes may run back to back
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		reg_wr   <= 1'b0;
		exp_q.push_back(e);
		@(posedge sys_clk);
	endtask : rd

	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	// Read data stands from the edge that takes the strobe until the next edge
	always @(posedge sys_clk) begin
		rd_q1 <= reg_rd;
		if (rd_q1 === 1'b1 && exp_q.size() > 0) begin
			check_rdata(reg_rdata, exp_q.pop_front());
		end
	end

	// Gate and data outputs have long settled by mid-cycle
	always @(negedge sys_clk) begin
		if (path_q.size() > 0) begin
			path_e = path_q.pop_front();
			check_data(data_out, path_e[3:0]);
			check_gate(gate_out, path_e[7:4]);
		end
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] cs;
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [3:0]  ed;
		logic [3:0]  eg;
		logic [3:0]  idx;
		logic [2:0]  f;
		logic        c1;
		logic        c2;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(ADDR_MIRROR, 8'h00);
		wr(ADDR_MIRROR, 8'hFF);
		rd(ADDR_MIRROR, 8'h00);
		wr(4'hF, 8'h5A);
		rd(4'hF, 8'h00);
		for (int g = 0; g < 4; g++) begin
			sel_m[g] = 8'($random(seed));
			wr(4'(g), sel_m[g]);
			rd(4'(g), sel_m[g]);
		end
		// Select registers must survive a reset in mid-run
		rst_n <= 1'b0;
		idle(3);
		rst_n <= 1'b1;
		idle(1);
		for (int g = 0; g < 4; g++) rd(4'(g), sel_m[g]);
		for (int i = 0; i < 24; i++) begin
			for (int g = 0; g < 4; g++) begin
				sel_m[g] = (g == i % 4) ? 8'h00 : 8'($random(seed));
				wr(4'(g), sel_m[g]);
			end
			lo = 8'($random(seed)) & 8'h77;
			hi = 8'($random(seed)) & 8'h77;
			wr(ADDR_SRC_LO, lo);
			wr(ADDR_SRC_HI, hi);
			cs = 16'($random(seed));
			c1 = 1'($random(seed));
			c2 = 1'($random(seed));
			cell_sources       <= cs;
			first_cell_output  <= c1;
			second_cell_output <= c2;
			idle(6);
			for (int k = 0; k < 4; k++) begin
				f = (k == 0) ? lo[2:0] : (k == 1) ? lo[6:4] : (k == 2) ? hi[2:0] : hi[6:4];
				idx = 4'(4 * k) + {1'b0, f};
				ed[k] = cs[idx];
			end
			for (int g = 0; g < 4; g++) begin
				eg[g] = 1'b0;
				for (int k = 0; k < 4; k++) begin
					eg[g] = eg[g] | (sel_m[g][2*k+1] & ed[k]) | (sel_m[g][2*k] & ~ed[k]);
				end
			end
			path_q.push_back({eg, ed});
			rd(ADDR_MIRROR, {6'h00, c2, c1});
		end
		idle(4);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
